// >>> core/sdcp_pkg.sv
// Constants and carrier types for the serial daisy-chain check port.
// Functional notes
// R1 - Host sets serial_out_enable before daisy transfers.
// R2 - Beyond frame length, oldest bits leave serial_out.
// R3 - Host sends 24 clocks per chained device, 32 with checking on.
// R4 - Frame select rise loads register, stops input.
// R5 - Checked frames are 32 bits with check byte.
// R6 - Check byte polynomial is x8+x2+x+1.
// R7 - Checked frame: rw, address, data, check fields.
// R8 - Host drives bit 30 of frames zero.
// R9 - Frame accepted only when remainder is zero.
// R10 - Failed write frame changes no register.
// R11 - Write echo returns rw, fail flag, address, data.
// R12 - Readback frames carry check over bits 31:8.
// R13 - Host issues second frame to fetch reads.
// R14 - Read echo returns register contents in 23:8; reads of ADDR_SPAN and ADDR_CODE return zero here.
// R15 - Any failed frame sets check_alarm.
// R16 - Enabled check alarm drives alert_out_n low.
// R17 - Host never writes unmapped addresses.
// R18 - No-operation write changes no state.
// R19 - Identification register read-only: part, revision.
// R20 - Unchecked frames 24 bits; short ignored, extra dropped.
// R21 - Serial input sampled on falling clock edges.
// R22 - Frame select high blocks clock, tristates output.
// R23 - fast_out_edge picks output change edge.
// R24 - Check byte MSB first, zero init, no inversion.
package sdcp_pkg;
  localparam logic [5:0] ADDR_NOP = 6'h00;
  localparam logic [5:0] ADDR_ID = 6'h01;
  localparam logic [5:0] ADDR_STATUS = 6'h02;
  localparam logic [5:0] ADDR_SPICFG = 6'h03;
  localparam logic [5:0] ADDR_GENCFG = 6'h04;
  localparam logic [5:0] ADDR_PWDN = 6'h09;
  localparam logic [5:0] ADDR_SPAN = 6'h0a;
  localparam logic [5:0] ADDR_TRIG = 6'h0e;
  localparam logic [5:0] ADDR_CODE = 6'h10;
  localparam logic [15:0] RST_SPICFG = 16'h0aa4;
  localparam logic [15:0] RST_GENCFG = 16'h4000;
  localparam logic [15:0] RST_PWDN = 16'hffff;
  localparam logic [15:0] RST_CODE = 16'h0000;
  localparam logic [3:0] RST_SPAN = 4'h0;
  localparam logic [3:0] RST_TRIG = 4'h0;
  localparam logic [15:0] SPICFG_WMASK = 16'h0e36;
  localparam logic [15:0] GENCFG_WMASK = 16'h4000;
  localparam logic [15:0] PWDN_WMASK = 16'h0001;
  localparam int CFG_FAST_BIT = 1;
  localparam int CFG_OUT_EN_BIT = 2;
  localparam int CFG_CHECK_EN_BIT = 4;
  localparam int CFG_DEV_PWDN_BIT = 5;
  localparam int CFG_ALARM_FLT_BIT = 9;
  localparam int GEN_REF_PWDN_BIT = 14;
  localparam int PWDN_OUT_BIT = 0;
  localparam int STAT_ALARM_BIT = 2;
  localparam logic [5:0] FRAME_SHORT = 6'h18;
  localparam logic [5:0] FRAME_LONG = 6'h20;
  localparam logic [5:0] CNT_MAX = 6'h3f;
  localparam logic [7:0] CRC_POLY = 8'h07;
  localparam logic [7:0] CRC_INIT = 8'h00;

  typedef struct packed {
    logic rw;
    logic flag;
    logic [5:0] addr;
    logic [15:0] data;
    logic [7:0] check;
  } sdcp_frame_type;

  typedef struct packed {
    sdcp_frame_type word;
    logic long_frame;
    logic out_en;
    logic fast_edge;
  } sdcp_link_type;
endpackage : sdcp_pkg

// >>> core/sdcp_crc8.sv
// Check byte generator over a parameterised number of message bits.
`timescale 1ns/100ps
module sdcp_crc8
#(
  parameter int W = 24
)
(
  input wire logic [W-1:0] data,
  output logic [7:0] crc
);
  import sdcp_pkg::*;

  always_comb
  begin
    logic [7:0] c;
    logic fb;
    c = CRC_INIT; // see R24
    fb = 1'b0;
    for (int i = W - 1; i >= 0; i--)
    begin
      fb = c[7] ^ data[i];
      c = {c[6:0], 1'b0} ^ (fb ? CRC_POLY : 8'h00); // see R6
    end
    crc = c;
  end
endmodule : sdcp_crc8

// >>> core/sdcp_port.sv
// Serial host port with daisy chain, frame check and register map.
`timescale 1ns/100ps
module sdcp_port
#(
  parameter logic [13:0] PART_CODE = 14'h0155,
  parameter logic [1:0] REV_CODE = 2'h1
)
(
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire logic sclk,
  input wire logic sync_n,
  input wire logic serial_in,
  output logic serial_out,
  output logic serial_out_oe,
  output logic alert_out_n,
  output logic dev_powerdown,
  output logic ref_powerdown,
  output logic out_powerdown,
  output logic [3:0] out_span,
  output logic [15:0] out_code
);
  import sdcp_pkg::*;

  // PART_CODE and REV_CODE defaults are arbitrary values.
  logic frame_idle;
  logic first_q;
  logic frame_tog_q;
  logic [5:0] cnt_q;
  logic [5:0] cnt_d;
  logic [31:0] sr_q;
  logic [23:0] head24_q;
  logic [31:0] head32_q;
  logic [5:0] idx;
  logic [5:0] out_len;
  logic [4:0] bit_sel;
  logic out_bit;
  logic out_r_q;
  sdcp_link_type link_q;
  logic sync_meta_q;
  logic sync_q;
  logic sync_prev_q;
  logic tog_meta_q;
  logic tog_q;
  logic tog_seen_q;
  logic frame_end;
  logic long_mode;
  logic daisy_mode;
  logic enough;
  logic ok;
  logic accept;
  logic wr_ok;
  logic rd_status;
  logic [7:0] rx_crc;
  logic [7:0] tx_crc;
  logic [15:0] rd_data;
  sdcp_frame_type fr;
  sdcp_frame_type resp;

  logic [15:0] cfg_q;
  logic [15:0] gen_q;
  logic [15:0] pwdn_q;
  logic [3:0] span_q;
  logic [3:0] trig_q;
  logic [15:0] code_q;
  logic alarm_q;
  logic alert_q;

  // Link side. Clock and data are ignored while frame select is high.
  assign frame_idle = sync_n | ~arst_n;

  always_ff @(negedge sclk or posedge frame_idle)
  begin
    if (frame_idle)
      first_q <= 1'b1;
    else
      first_q <= 1'b0;
  end

  assign cnt_d = first_q ? 6'h01 :
                 (cnt_q == CNT_MAX ? cnt_q : cnt_q + 6'h01);

  // The count is kept through idle so the core can judge the frame length.
  always_ff @(negedge sclk or negedge arst_n)
  begin
    if (!arst_n)
      cnt_q <= 6'h00;
    else if (!sync_n)
      cnt_q <= cnt_d; // see R22
  end

  always_ff @(negedge sclk or negedge arst_n)
  begin
    if (!arst_n)
      frame_tog_q <= 1'b0;
    else if (!sync_n && first_q)
      frame_tog_q <= ~frame_tog_q;
  end

  always_ff @(negedge sclk or negedge arst_n)
  begin
    if (!arst_n)
      sr_q <= 32'h0000_0000;
    else if (!sync_n)
      sr_q <= {sr_q[30:0], serial_in}; // see R21
  end

  // Heads hold the first bits of a frame for the stand-alone case.
  always_ff @(negedge sclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      head24_q <= 24'h00_0000;
      head32_q <= 32'h0000_0000;
    end
    else if (!sync_n)
    begin
      if (cnt_d == FRAME_SHORT)
        head24_q <= {sr_q[22:0], serial_in}; // see R20
      if (cnt_d == FRAME_LONG)
        head32_q <= {sr_q[30:0], serial_in}; // see R5
    end
  end

  // The answer word is steady for the whole frame, so it is read here
  // without a synchroniser; frame select guards it like a handshake.
  assign idx = first_q ? 6'h00 : cnt_q;
  assign out_len = link_q.long_frame ? FRAME_LONG : FRAME_SHORT;
  assign bit_sel = 5'h1f - idx[4:0];

  always_comb
  begin
    if (idx < out_len)
      out_bit = link_q.word[bit_sel];
    else if (link_q.long_frame)
      out_bit = sr_q[31]; // see R2
    else
      out_bit = sr_q[23]; // see R2
  end

  always_ff @(posedge sclk or negedge arst_n)
  begin
    if (!arst_n)
      out_r_q <= 1'b0;
    else
      out_r_q <= out_bit;
  end

  assign serial_out = link_q.fast_edge ? out_bit : out_r_q; // see R23
  assign serial_out_oe = ~sync_n & link_q.out_en; // see R22

  // Core side. Frame select and the frame toggle are synchronised.
  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      sync_meta_q <= 1'b1;
      sync_q <= 1'b1;
      sync_prev_q <= 1'b1;
      tog_meta_q <= 1'b0;
      tog_q <= 1'b0;
      tog_seen_q <= 1'b0;
    end
    else
    begin
      sync_meta_q <= sync_n;
      sync_q <= sync_meta_q;
      sync_prev_q <= sync_q;
      tog_meta_q <= frame_tog_q;
      tog_q <= tog_meta_q;
      if (frame_end)
        tog_seen_q <= tog_q;
    end
  end

  assign frame_end = sync_q & ~sync_prev_q; // see R4
  assign long_mode = cfg_q[CFG_CHECK_EN_BIT];
  assign daisy_mode = cfg_q[CFG_OUT_EN_BIT];

  // In a chain the last bits belong to this device; alone, the first do.
  always_comb
  begin
    if (long_mode)
      fr = daisy_mode ? sr_q : head32_q; // see R7
    else
      fr = {(daisy_mode ? sr_q[23:0] : head24_q), 8'h00}; // see R20
  end

  assign enough = (tog_q != tog_seen_q) &&
                  (cnt_q >= (long_mode ? FRAME_LONG : FRAME_SHORT));

  sdcp_crc8 #(.W(24)) u_rx_crc
  (
    .data(fr[31:8]),
    .crc(rx_crc)
  );

  // Matching byte is the same as a zero remainder over all 32 bits.
  assign ok = !long_mode || (rx_crc == fr.check); // see R9
  assign accept = frame_end && enough;
  assign wr_ok = accept && ok && !fr.rw; // see R10

  assign rd_status = accept && ok && fr.rw && (fr.addr == ADDR_STATUS);

  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      cfg_q <= RST_SPICFG;
      gen_q <= RST_GENCFG;
      pwdn_q <= RST_PWDN;
      span_q <= RST_SPAN;
      trig_q <= RST_TRIG;
      code_q <= RST_CODE;
    end
    else if (wr_ok)
    begin
      // Unlisted addresses, the identity and no-operation fall through.
      case (fr.addr) // see R18
        ADDR_SPICFG:
          cfg_q <= (cfg_q & ~SPICFG_WMASK) | (fr.data & SPICFG_WMASK);
        ADDR_GENCFG:
          gen_q <= (gen_q & ~GENCFG_WMASK) | (fr.data & GENCFG_WMASK);
        ADDR_PWDN:
          pwdn_q <= (pwdn_q & ~PWDN_WMASK) | (fr.data & PWDN_WMASK);
        ADDR_SPAN:
          span_q <= fr.data[3:0];
        ADDR_TRIG:
          trig_q <= fr.data[3:0];
        ADDR_CODE:
          code_q <= fr.data; // see R4
        default:
          cfg_q <= cfg_q; // see R19
      endcase
    end
  end

  // The alarm is sticky; a good status read clears it, a new failure wins.
  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
      alarm_q <= 1'b0;
    else if (accept && !ok)
      alarm_q <= 1'b1; // see R15
    else if (rd_status)
      alarm_q <= 1'b0;
  end

  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
      alert_q <= 1'b0;
    else
      alert_q <= alarm_q & cfg_q[CFG_ALARM_FLT_BIT]; // see R16
  end

  always_comb
  begin
    case (fr.addr)
      ADDR_ID:
        rd_data = {PART_CODE, REV_CODE}; // see R19
      ADDR_STATUS:
        rd_data = 16'(alarm_q) << STAT_ALARM_BIT;
      ADDR_SPICFG:
        rd_data = cfg_q;
      ADDR_GENCFG:
        rd_data = gen_q;
      ADDR_PWDN:
        rd_data = pwdn_q;
      ADDR_TRIG:
        rd_data = {12'h000, trig_q};
      default:
        rd_data = 16'h0000;
    endcase
  end

  always_comb
  begin
    resp = fr;
    resp.flag = long_mode ? ~ok : fr.flag; // see R11
    resp.data = fr.rw ? rd_data : fr.data; // see R14
    resp.check = 8'h00;
  end

  sdcp_crc8 #(.W(24)) u_tx_crc
  (
    .data(resp[31:8]),
    .crc(tx_crc)
  );

  // Config copies only move while no frame is running on the link.
  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
      link_q <= {32'h0000_0000, RST_SPICFG[CFG_CHECK_EN_BIT],
                 RST_SPICFG[CFG_OUT_EN_BIT], RST_SPICFG[CFG_FAST_BIT]};
    else if (sync_q)
    begin
      if (accept)
      begin
        link_q.word <= resp;
        link_q.word.check <= long_mode ? tx_crc : 8'h00; // see R12
      end
      link_q.long_frame <= long_mode;
      link_q.out_en <= daisy_mode;
      link_q.fast_edge <= cfg_q[CFG_FAST_BIT];
    end
  end

  assign alert_out_n = ~alert_q;
  assign dev_powerdown = cfg_q[CFG_DEV_PWDN_BIT];
  assign ref_powerdown = gen_q[GEN_REF_PWDN_BIT];
  assign out_powerdown = pwdn_q[PWDN_OUT_BIT];
  assign out_span = span_q;
  assign out_code = code_q;

  // Helper check of the answer word's own check byte.
  logic [7:0] chk_crc;

  sdcp_crc8 #(.W(24)) u_chk_crc
  (
    .data(link_q.word[31:8]),
    .crc(chk_crc)
  );

  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!arst_n);

  AST_SHORT_IGNORED: assert property ( // see R20
    frame_end && !enough |=> $stable(cfg_q) && $stable(code_q)
      && $stable(link_q.word))
    else $error("Short frame changed state.");
  AST_BAD_NO_WRITE: assert property ( // see R10
    accept && !ok |=> $stable(cfg_q) && $stable(gen_q) && $stable(pwdn_q)
      && $stable(span_q) && $stable(code_q))
    else $error("Failed frame wrote a register.");
  AST_BAD_SETS_ALARM: assert property ( // see R15
    accept && !ok |=> alarm_q)
    else $error("Failed frame did not set the alarm.");
  AST_ALERT_LOW: assert property ( // see R16
    alarm_q && cfg_q[CFG_ALARM_FLT_BIT] |=> ##[0:1] !alert_out_n)
    else $error("Alarm did not pull alert low.");
  AST_ECHO_FLAG: assert property ( // see R11
    accept && long_mode |=> link_q.word.flag == !$past(ok)
      && link_q.word.addr == $past(fr.addr))
    else $error("Echoed fail flag or address wrong.");
  AST_RESP_CHECK: assert property ( // see R12
    accept && long_mode |=> link_q.word.check == chk_crc)
    else $error("Answer check byte wrong.");
  AST_READ_CFG: assert property ( // see R14
    accept && ok && fr.rw && fr.addr == ADDR_SPICFG
      |=> link_q.word.data == $past(cfg_q))
    else $error("Read data does not match register.");
  AST_NOP_STABLE: assert property ( // see R18
    accept && ok && !fr.rw && fr.addr == ADDR_NOP
      |=> $stable(cfg_q) && $stable(gen_q) && $stable(pwdn_q)
      && $stable(code_q) && $stable(alarm_q))
    else $error("No-operation changed state.");
  AST_ID_READ: assert property ( // see R19
    accept && ok && fr.rw && fr.addr == ADDR_ID
      |=> link_q.word.data == {PART_CODE, REV_CODE})
    else $error("Identity readback wrong.");
  AST_CODE_LOAD: assert property ( // see R4
    wr_ok && fr.addr == ADDR_CODE |=> out_code == $past(fr.data))
    else $error("Code not loaded at frame end.");
endmodule : sdcp_port

// >>> tb/sdcp_host.sv
// Host controller model that drives frames into the serial port.
`timescale 1ns/100ps
module sdcp_host
(
  output logic sclk,
  output logic sync_n,
  output logic serial_in,
  input wire logic sdo,
  output logic [63:0] rx_word,
  output logic rx_tgl
);
  initial
  begin
    sclk = 1'b0;
    sync_n = 1'b1;
    serial_in = 1'b0;
    rx_word = '0;
    rx_tgl = 1'b0;
  end

  // Sends n bits MSB first from the top of w and collects what comes back.
  // The clock stands low outside frames, so fast_out_edge clear still gets
  // a rising edge before the first bit is taken.
  task automatic frame(input logic [63:0] w, input int n);
    rx_word = '0;
    sync_n = 1'b0;
    #40;
    for (int i = 0; i < n; i++)
    begin
      #1 serial_in = w[63-i];
      #5 sclk = 1'b1;
      #5 rx_word = {rx_word[62:0], sdo};
      #1 sclk = 1'b0;
    end
    #6 sync_n = 1'b1;
    serial_in = ~serial_in;
    rx_tgl = ~rx_tgl;
    // Idle long enough for the port to cross and process the frame.
    #100;
  endtask : frame
endmodule : sdcp_host

// >>> tb/tb.sv
// Self-checking bench for the serial daisy-chain check port.
`timescale 1ns/100ps
module tb;
  import sdcp_pkg::*;
  // Identification value matches the arbitrary defaults of the port.
  localparam logic [15:0] ID = {14'h0155, 2'h1};
  logic ref_clk = 1'b0;
  logic arst_n = 1'b0;
  logic sclk, sync_n, serial_in, sdo_w, serial_out, serial_out_oe;
  logic alert_out_n, dev_powerdown, ref_powerdown, out_powerdown;
  logic [3:0] out_span;
  logic [15:0] out_code, d;
  logic [63:0] rx_word, pm;
  logic rx_tgl, crc_on;
  logic [31:0] prev;
  logic [63:0] eq[$], mq[$];
  int miscompares = 0;
  int checks_done = 0;
  int cycles = 0;

  assign sdo_w = serial_out_oe ? serial_out : 1'bz;

  sdcp_port u_sdcp_port (.ref_clk(ref_clk), .arst_n(arst_n), .sclk(sclk),
    .sync_n(sync_n), .serial_in(serial_in), .serial_out(serial_out),
    .serial_out_oe(serial_out_oe), .alert_out_n(alert_out_n),
    .dev_powerdown(dev_powerdown), .ref_powerdown(ref_powerdown),
    .out_powerdown(out_powerdown), .out_span(out_span),
    .out_code(out_code));

  sdcp_host u_sdcp_host (.sclk(sclk), .sync_n(sync_n),
    .serial_in(serial_in), .sdo(sdo_w), .rx_word(rx_word), .rx_tgl(rx_tgl));

  always #4 ref_clk = ~ref_clk;

  task automatic end_of_test();
    $display("checks %0d miscompares %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : end_of_test

  always @(posedge ref_clk)
  begin
    cycles++;
    if (cycles == 10000)
    begin
      miscompares++;
      end_of_test();
    end
  end

  task automatic check(input string name, input logic [63:0] seen,
    input logic [63:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  always @(rx_tgl)
  begin
    if (eq.size() > 0)
      check("answer", rx_word & mq.pop_front(), eq.pop_front());
  end

  function automatic logic [7:0] crc8(input logic [23:0] m);
    logic [7:0] c;
    c = 8'h00;
    for (int i = 23; i >= 0; i--)
      c = {c[6:0], 1'b0} ^ ((c[7] ^ m[i]) ? 8'h07 : 8'h00);
    return c;
  endfunction : crc8

  function automatic logic [23:0] fr(input logic rw, input logic [5:0] a,
    input logic [15:0] v);
    return {rw, 1'b0, a, v};
  endfunction : fr

  // Sends one frame and notes the answer owed by the frame before it.
  task automatic xfer(input logic [23:0] w, input logic [31:0] ans,
    input logic bad = 1'b0);
    logic [63:0] e;
    e = crc_on ? {prev[31:8], crc8(prev[31:8])} : prev[31:8];
    eq.push_back(e & pm);
    mq.push_back(pm);
    pm = crc_on ? 64'hffffffff : 64'hffffff;
    prev = ans;
    if (crc_on)
      u_sdcp_host.frame({w, crc8(w) ^ {7'h0, bad}, 32'h0}, 32);
    else
      u_sdcp_host.frame({w, 40'h0}, 24);
  endtask : xfer

  task automatic wr(input logic [5:0] a, input logic [15:0] v);
    xfer(fr(1'b0, a, v), {fr(1'b0, a, v), 8'h0});
  endtask : wr

  // The fetch frame that follows every read is the next call.
  task automatic rd(input logic [5:0] a, input logic [15:0] v);
    xfer(fr(1'b1, a, 16'h0), {fr(1'b1, a, v), 8'h0});
  endtask : rd

  initial
  begin
    void'($urandom(32'h7c65b363));
    crc_on = 1'b0;
    pm = '0;
    prev = '0;
    repeat (16) @(posedge ref_clk);
    arst_n <= 1'b1;
    repeat (4) @(posedge ref_clk);
    check("pins", {dev_powerdown, ref_powerdown, out_powerdown,
      alert_out_n, out_span, out_code}, {4'hf, 20'h0});
    check("oe idle", serial_out_oe, 1'b0);
    rd(ADDR_SPICFG, RST_SPICFG);
    rd(ADDR_GENCFG, RST_GENCFG);
    rd(ADDR_PWDN, RST_PWDN);
    wr(ADDR_ID, 16'h0);
    rd(ADDR_ID, ID);
    rd(ADDR_STATUS, 16'h0);
    for (int k = 0; k < 4; k++)
    begin
      d = 16'($urandom);
      wr(ADDR_CODE, d);
      check("code", out_code, d);
      wr(ADDR_SPAN, {12'h0, d[3:0]});
      check("span", out_span, d[3:0]);
    end
    wr(ADDR_NOP, 16'h0);
    check("nop", out_code, d);
    rd(ADDR_CODE, 16'h0);
    wr(ADDR_PWDN, 16'h0);
    wr(ADDR_GENCFG, 16'h0);
    wr(ADDR_SPICFG, 16'h0a84);
    rd(ADDR_PWDN, 16'hfffe);
    check("pdn", {dev_powerdown, ref_powerdown, out_powerdown},
      3'h0);
    // A frame one bit short must leave everything alone.
    eq.push_back(prev[31:9]);
    mq.push_back(64'h7fffff);
    u_sdcp_host.frame({fr(1'b0, ADDR_CODE, 16'hbeef), 40'h0}, 23);
    check("short", out_code, d);
    // Two chained devices: the far one gets the first word.
    eq.push_back({prev[31:8], fr(1'b0, ADDR_CODE, 16'h1111)});
    mq.push_back(64'hffffffffffff);
    u_sdcp_host.frame({fr(1'b0, ADDR_CODE, 16'h1111),
      fr(1'b0, ADDR_CODE, 16'h2222), 16'h0}, 48);
    prev = {fr(1'b0, ADDR_CODE, 16'h2222), 8'h0};
    check("chain", out_code, 16'h2222);
    wr(ADDR_SPICFG, 16'h0a94);
    crc_on = 1'b1;
    // The answer word was formed before checking was on.
    pm = 64'hffffff00;
    wr(ADDR_CODE, 16'h1234);
    check("crc good", out_code, 16'h1234);
    xfer(fr(1'b0, ADDR_CODE, 16'h5a5a),
      {1'b0, 1'b1, ADDR_CODE, 16'h5a5a, 8'h0}, 1'b1);
    check("crc bad", out_code, 16'h1234);
    check("alert", alert_out_n, 1'b0);
    xfer(fr(1'b1, ADDR_SPICFG, 16'h0),
      {1'b1, 1'b1, ADDR_SPICFG, 16'h0a94, 8'h0}, 1'b1);
    rd(ADDR_STATUS, 16'h0004);
    rd(ADDR_STATUS, 16'h0000);
    check("alert off", alert_out_n, 1'b1);
    wr(ADDR_SPICFG, 16'h0a96);
    rd(ADDR_ID, ID);
    wr(ADDR_NOP, 16'h0);
    end_of_test();
  end
endmodule : tb
